// [common/itc_pkg.sv]
// Constants shared by the interval timer channel block.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave port.
package itc_pkg;
  // Clock rate in kHz and the documented timings
  localparam int CLK_KHZ = 25000;
  localparam int INTERVAL_MS = 5;
  localparam int SAMPLE_MS = 50;
  // Interval in system clock cycles, and interrupts per switch sample
  localparam int INTERVAL_CYC = INTERVAL_MS * CLK_KHZ;
  localparam int SAMPLE_DIV = SAMPLE_MS / INTERVAL_MS;
  // Register byte offsets
  localparam logic [7:0] A_RESET = 8'h00;
  localparam logic [7:0] A_CLKEN = 8'h04;
  localparam logic [7:0] A_TPS = 8'h08;
  localparam logic [7:0] A_STOP = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_FLAG = 8'h14;
  localparam logic [7:0] A_PRIO0 = 8'h18;
  localparam logic [7:0] A_PRIO1 = 8'h1C;
  localparam logic [7:0] A_MODE = 8'h20;
  localparam logic [7:0] A_DATA = 8'h24;
  localparam logic [7:0] A_START = 8'h28;
  localparam logic [7:0] A_STATUS = 8'h2C;
  // Field positions
  localparam int B_UNIT = 0;
  localparam int B_IRQ = 5;
  localparam int CH = 3;
  localparam int B_HI3 = 11;
  localparam int B_HI1 = 9;
  localparam int TPS_P0 = 0;
  localparam int TPS_P1 = 4;
  localparam int TPS_P2 = 8;
  localparam int TPS_P3 = 12;
  localparam int MODE_CKS = 14;
  localparam int MODE_CCS = 12;
  localparam int MODE_MD0 = 0;
  // Reset values
  localparam logic [7:0] RST_PRR = 8'h01;
  localparam logic [7:0] RST_PER = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'hFF;
  localparam logic [15:0] RST_TPS = 16'h0001;
  localparam logic [15:0] RST_MODE = 16'h0000;
  // Data value giving the interval with the reset prescale of two
  localparam int DATA_RST = INTERVAL_CYC / 2 - 1;
  // Operating clock select codes, in code order 00 to 11
  typedef enum logic [1:0] {
    ITC_SEL_T0,
    ITC_SEL_T2,
    ITC_SEL_T1,
    ITC_SEL_T3
  } itc_cks_t;
endpackage

// [verilog/itc_prescaler.sv]
// Prescaler producing the four operating clock taps as enable pulses.
// Assumes run is low while the unit is held in reset or ungated.
`timescale 1ns/1ps
module itc_prescaler (
  input wire logic clk, // System clock
  input wire logic rst, // Unit reset, active high
  input wire logic run, // Unit clock supplied
  input wire logic [3:0] prs0, // Tap 0 exponent
  input wire logic [3:0] prs1, // Tap 1 exponent
  input wire logic [1:0] prs2, // Tap 2 exponent
  input wire logic [1:0] prs3, // Tap 3 exponent
  output logic [3:0] tap // One-cycle tap pulses
);
  import itc_pkg::*;

  logic [14:0] div_r; // Free running divider
  logic [3:0] exps [4]; // Exponent per tap

  // True when the low exp bits of the divider are all ones
  function automatic logic tap_hit(input logic [14:0] c,
                                   input logic [3:0] e);
    logic [15:0] m;
    m = (16'h0001 << e) - 16'h0001;
    return (c & m[14:0]) == m[14:0];
  endfunction

  assign exps[0] = prs0;
  assign exps[1] = prs1;
  assign exps[2] = {2'b00, prs2};
  assign exps[3] = {2'b00, prs3};

  // Tap k fires once every two-to-the-exponent cycles, see R3
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tap
      assign tap[g] = run & tap_hit(div_r, exps[g]);
    end
  endgenerate

  // Divider advances only while the unit clock runs
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= 15'h0000;
    end else if (run) begin
      div_r <= div_r + 15'h0001;
    end
  end

  // Exponent one gives a pulse every second cycle
  a_tap_period: assert property (@(posedge clk) disable iff (rst) // see R3
    (run && prs0 == 4'h1 && tap[0]) ##1 (run && $stable(prs0))
      |-> !tap[0] ##1 (!run || tap[0] || prs0 != 4'h1))
    else $error("tap 0 period wrong for exponent one");
endmodule

// [verilog/itc_channel.sv]
// Down counting interval channel with reload on reaching zero.
// Assumes tick is a one-cycle count enable and start a one-cycle pulse.
`timescale 1ns/1ps
module itc_channel #(
  parameter int W = 16 // Counter width
) (
  input wire logic clk, // System clock
  input wire logic rst, // Unit reset, active high
  input wire logic en, // Channel enable flag
  input wire logic start, // Start pulse, loads the data value
  input wire logic tick, // Counting clock pulse
  input wire logic md0, // Interrupt also at start
  input wire logic [W-1:0] load, // Data value
  output logic [W-1:0] cnt, // Current count
  output logic end_pulse // One-cycle interval end
);
  import itc_pkg::*;

  logic [W-1:0] cnt_r; // Counter
  logic [W-1:0] cnt_nxt; // Next count
  logic zero; // Counter at end

  assign zero = cnt_r == '0;
  // Count down, reload at the end, see R13
  assign cnt_nxt = start ? load :
                   (en && tick) ? (zero ? load : cnt_r - 1'b1) : cnt_r;
  // End of period, or start when so configured
  assign end_pulse = (en & tick & zero & ~start) | (start & md0);
  assign cnt = cnt_r;

  // Counter register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_reload_value: assert property (@(posedge clk) disable iff (rst) // see R13
    (en && tick && zero && !start) |=> cnt_r == $past(load))
    else $error("counter did not reload at end");

  a_count_down: assert property (@(posedge clk) disable iff (rst) // see R13
    (en && tick && !zero && !start) |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("counter did not decrement");
endmodule

// [verilog/itc_top.sv]
// Interval timer unit with one counting channel and its interrupt setup.
// Assumes a classic Wishbone master and synchronous input pins.
// Function
// R1: Reset bit one holds unit in reset
// R2: Clock enable bit gates unit clock
// R3: Prescaler divides by two to field power
// R4: Stop bit one clears channel enable
// R5: Software stops channels before configuring
// R6: Mask bit one blocks the interrupt
// R7: Flag reads one once request raised
// R8: Software clears flag, masks before enabling
// R9: Two priority bits choose level zero-three
// R10: Select code picks taps 0,2,1,3
// R11: Count select zero counts operating clock
// R12: Interrupt every 5 ms, sample 50 ms
// R13: Count down, interrupt at end, reload
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module itc_top #(
  parameter int DATA_RESET = itc_pkg::DATA_RST, // Reset data value
  parameter int SAMPLE_COUNT = itc_pkg::SAMPLE_DIV // Ends per sample
) (
  input wire logic clk, // System clock, 25 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic count_event_in, // External count event
  input wire logic switch_input_pin, // Switch level
  output logic channel3_irq, // Unmasked pending request
  output logic [1:0] irq_level, // Interrupt priority level
  output logic interval_pulse, // One-cycle interval end
  output logic display_group, // Display four-bit group select
  output logic switch_sample, // One-cycle switch sample strobe
  output logic switch_state // Last sampled switch level
);
  import itc_pkg::*;

  // Registers
  logic [7:0] prr_r; // periph_reset_ctl
  logic [7:0] per_r; // periph_clock_enable
  logic [15:0] tps_r; // timer_prescale_select
  logic [7:0] mask_r; // intr_mask_low1
  logic [7:0] flag_r; // intr_flag_low1
  logic [7:0] pr0_r; // intr_priority0_low1
  logic [7:0] pr1_r; // intr_priority1_low1
  logic [15:0] mode_r; // channel3_mode
  logic [15:0] data_r; // Channel data value
  logic [3:0] en_r; // channel_enable_flag per channel
  logic [3:0] en_nxt; // Next enable flags
  logic ack_r; // Bus acknowledge
  logic [31:0] rdat_r; // Read data
  logic ev_q_r; // Event input delayed
  logic grp_r; // Display group
  logic [7:0] samp_cnt_r; // Interval ends since last sample
  logic samp_r; // Sample strobe
  logic sw_r; // Sampled switch

  // Bus decode
  logic req; // New request this cycle
  logic wr; // Write taken
  logic [31:0] rdat; // Read mux
  logic unit_rst; // Unit held in reset
  logic run; // Unit clock supplied
  logic [3:0] tap; // Tap pulses
  logic op_tick; // Operating clock pulse
  logic ev_tick; // External event pulse
  logic cnt_tick; // Counting clock pulse
  logic ch_start; // Channel start pulse
  logic ch_end; // Interval end
  logic [15:0] ch_cnt; // Channel count
  logic [1:0] cks; // Operating clock select
  logic samp_hit; // Sample due
  logic [31:0] wlane; // Written lanes merged over zero
  logic [31:0] tps_w; // Prescale value with written lanes
  logic [31:0] mode_w; // Mode value with written lanes
  logic [31:0] data_w; // Data value with written lanes

  // Merge written byte lanes into an old value
  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // True for a write to the given offset
  function automatic logic wr_at(input logic w, input logic [7:0] a,
                                 input logic [7:0] off);
    return w && a == off;
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i;
  assign unit_rst = rst | prr_r[B_UNIT]; // see R1
  assign run = per_r[B_UNIT] & ~prr_r[B_UNIT]; // see R2

  // Start and stop triggers for the channel, see R4
  assign ch_start = run & wr_at(wr, wb_adr_i, A_START) & wb_sel_i[0] &
                    wb_dat_i[CH];
  assign wlane = lanes(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign en_nxt = (run && wr_at(wr, wb_adr_i, A_STOP)) ?
                  en_r & ~(wlane[3:0] |
                  {wlane[B_HI3], 1'b0, wlane[B_HI1], 1'b0}) :
                  (run && wr_at(wr, wb_adr_i, A_START)) ?
                  en_r | wlane[3:0] :
                  en_r;

  // Operating clock select, codes 00,01,10,11 give taps 0,2,1,3, see R10
  assign cks = mode_r[MODE_CKS +: 2];
  assign op_tick = (cks == ITC_SEL_T0) ? tap[0] :
                   (cks == ITC_SEL_T2) ? tap[2] :
                   (cks == ITC_SEL_T1) ? tap[1] : tap[3];
  // Counting clock: operating clock or external event, see R11
  assign ev_tick = run & count_event_in & ~ev_q_r;
  assign cnt_tick = mode_r[MODE_CCS] ? ev_tick : op_tick;

  // Prescaler taps
  itc_prescaler u_pre (
    .clk(clk),
    .rst(unit_rst),
    .run(run),
    .prs0(tps_r[TPS_P0 +: 4]),
    .prs1(tps_r[TPS_P1 +: 4]),
    .prs2(tps_r[TPS_P2 +: 2]),
    .prs3(tps_r[TPS_P3 +: 2]),
    .tap(tap)
  );

  // Interval channel, see R13
  itc_channel #(.W(16)) u_ch (
    .clk(clk),
    .rst(unit_rst),
    .en(en_r[CH]),
    .start(ch_start),
    .tick(cnt_tick),
    .md0(mode_r[MODE_MD0]),
    .load(data_r),
    .cnt(ch_cnt),
    .end_pulse(ch_end)
  );

  // Request visible only while unmasked, see R6
  assign channel3_irq = flag_r[B_IRQ] & ~mask_r[B_IRQ];
  // Priority code: high bit from second register, see R9
  assign irq_level = {pr1_r[B_IRQ], pr0_r[B_IRQ]};
  assign interval_pulse = ch_end; // see R12
  assign samp_hit = ch_end && samp_cnt_r == 8'(SAMPLE_COUNT - 1);

  // Read selection; unmapped and write-only offsets read zero
  assign rdat =
    (wb_adr_i == A_RESET) ? {24'h00_0000, prr_r} :
    (wb_adr_i == A_CLKEN) ? {24'h00_0000, per_r} :
    (wb_adr_i == A_TPS) ? {16'h0000, tps_r} :
    (wb_adr_i == A_MASK) ? {24'h00_0000, mask_r} :
    (wb_adr_i == A_FLAG) ? {24'h00_0000, flag_r} :
    (wb_adr_i == A_PRIO0) ? {24'h00_0000, pr0_r} :
    (wb_adr_i == A_PRIO1) ? {24'h00_0000, pr1_r} :
    (wb_adr_i == A_MODE) ? {16'h0000, mode_r} :
    (wb_adr_i == A_DATA) ? {16'h0000, data_r} :
    (wb_adr_i == A_STATUS) ? {ch_cnt, 7'h00, sw_r, 4'h0, en_r} :
    32'h0000_0000;

  // Bus answer: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      rdat_r <= req ? rdat : rdat_r;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // System control registers, kept across unit reset, see R1 R2
  always_ff @(posedge clk) begin
    if (rst) begin
      prr_r <= RST_PRR;
      per_r <= RST_PER;
    end else begin
      if (wr_at(wr, wb_adr_i, A_RESET) && wb_sel_i[0]) begin
        prr_r <= wb_dat_i[7:0];
      end
      if (wr_at(wr, wb_adr_i, A_CLKEN) && wb_sel_i[0]) begin
        per_r <= wb_dat_i[7:0];
      end
    end
  end

  // Interrupt controller bits; a set in the clearing cycle wins, see R7
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= RST_MASK;
      flag_r <= RST_FLAG;
      pr0_r <= RST_PRIO;
      pr1_r <= RST_PRIO;
    end else begin
      if (wr_at(wr, wb_adr_i, A_MASK) && wb_sel_i[0]) begin
        mask_r <= wb_dat_i[7:0];
      end
      if (wr_at(wr, wb_adr_i, A_PRIO0) && wb_sel_i[0]) begin
        pr0_r <= wb_dat_i[7:0];
      end
      if (wr_at(wr, wb_adr_i, A_PRIO1) && wb_sel_i[0]) begin
        pr1_r <= wb_dat_i[7:0];
      end
      flag_r <= ((wr_at(wr, wb_adr_i, A_FLAG) && wb_sel_i[0]) ?
                 wb_dat_i[7:0] : flag_r) |
                {2'b00, ch_end, 5'b0_0000};
    end
  end

  // Unit register values with the written byte lanes merged in
  assign tps_w = lanes({16'h0000, tps_r}, wb_dat_i, wb_sel_i);
  assign mode_w = lanes({16'h0000, mode_r}, wb_dat_i, wb_sel_i);
  assign data_w = lanes({16'h0000, data_r}, wb_dat_i, wb_sel_i);

  // Timer unit registers; writes need the unit clock, see R2
  always_ff @(posedge clk) begin
    if (unit_rst) begin
      tps_r <= RST_TPS;
      mode_r <= RST_MODE;
      data_r <= 16'(DATA_RESET);
      en_r <= 4'h0;
      ev_q_r <= 1'b0;
    end else if (run) begin
      if (wr_at(wr, wb_adr_i, A_TPS)) begin
        tps_r <= tps_w[15:0];
      end
      if (wr_at(wr, wb_adr_i, A_MODE)) begin
        mode_r <= mode_w[15:0];
      end
      if (wr_at(wr, wb_adr_i, A_DATA)) begin
        data_r <= data_w[15:0];
      end
      en_r <= en_nxt;
      ev_q_r <= count_event_in;
    end
  end

  // Display group advance per interval, switch sampling every SAMPLE_COUNT intervals, see R12
  always_ff @(posedge clk) begin
    if (rst) begin
      grp_r <= 1'b0;
      samp_cnt_r <= 8'h00;
      samp_r <= 1'b0;
      sw_r <= 1'b0;
    end else begin
      samp_r <= samp_hit;
      if (ch_end) begin
        grp_r <= ~grp_r;
        samp_cnt_r <= samp_hit ? 8'h00 : samp_cnt_r + 8'h01;
      end
      if (samp_hit) begin
        sw_r <= switch_input_pin;
      end
    end
  end
  assign display_group = grp_r;
  assign switch_sample = samp_r;
  assign switch_state = sw_r;

  // Checks
  a_reset_hold: assert property (@(posedge clk) disable iff (rst) // see R1
    prr_r[B_UNIT] |-> tap == 4'h0 ##1 en_r == 4'h0)
    else $error("unit active while reset bit set");

  a_clock_gate: assert property (@(posedge clk) disable iff (rst) // see R2
    (!per_r[B_UNIT] && !prr_r[B_UNIT]) |-> !ch_end ##1 $stable(ch_cnt))
    else $error("channel moved without unit clock");

  a_stop_clears: assert property (@(posedge clk) disable iff (rst) // see R4
    (run && wr && wb_adr_i == A_STOP && wb_sel_i[0] && wb_dat_i[CH])
      |=> !en_r[CH] ##1 $stable(ch_cnt))
    else $error("stop trigger did not clear enable");

  a_mask_gates: assert property (@(posedge clk) disable iff (rst) // see R6
    channel3_irq |-> !mask_r[B_IRQ] && flag_r[B_IRQ])
    else $error("masked request reached output");

  a_flag_sets: assert property (@(posedge clk) disable iff (rst) // see R7
    ch_end |=> flag_r[B_IRQ] && display_group != $past(display_group))
    else $error("interval end did not set flag");

  a_prio_level: assert property (@(posedge clk) disable iff (rst) // see R9
    (pr1_r[B_IRQ] && !pr0_r[B_IRQ]) |-> irq_level == 2'b10)
    else $error("priority level mismatch");

  a_op_select: assert property (@(posedge clk) disable iff (rst) // see R10
    (cks == 2'b01 && tap[2] && !mode_r[MODE_CCS] && en_r[CH] && run &&
     !ch_start && ch_cnt != 16'h0000) |=> ch_cnt == $past(ch_cnt) - 1'b1)
    else $error("code 01 did not count on tap 2");

  a_count_src: assert property (@(posedge clk) disable iff (rst) // see R11
    (!mode_r[MODE_CCS] && !op_tick && !ch_start && !unit_rst)
      |=> $stable(ch_cnt))
    else $error("counted without operating clock");

  a_sample_step: assert property (@(posedge clk) disable iff (rst) // see R12
    switch_sample |-> samp_cnt_r == 8'h00 && $past(ch_end))
    else $error("switch sample off the interval boundary");
endmodule

// [tb/testbench.sv]
// Self-checking bench for the interval timer channel block.
// Assumes itc_top with its Wishbone port and a 25 MHz system clock.
`timescale 1ns/1ps
module testbench;
  import itc_pkg::*;
  localparam int DR = 9; // Shortened data value
  localparam int SC = 3; // Shortened ends per switch sample
  logic clk = 1'b0; // System clock
  logic rst = 1'b1; // Synchronous reset
  logic cyc = 1'b0; // Bus cycle
  logic stb = 1'b0; // Bus strobe
  logic we = 1'b0; // Bus write
  logic [7:0] adr = 8'h00; // Bus address
  logic [31:0] dat = 32'h0000_0000; // Bus write data
  logic pin = 1'b0; // Switch level
  logic ev = 1'b0; // External count event level
  wire logic [31:0] wb_dat_o; // Read data
  wire logic wb_ack_o; // Acknowledge
  wire logic channel3_irq; // Pending request
  wire logic [1:0] irq_level; // Priority level
  wire logic interval_pulse; // Interval end
  wire logic display_group; // Display group select
  wire logic switch_sample; // Sample strobe
  wire logic switch_state; // Sampled switch
  int n_mismatch = 0; // Mismatch count
  int n_checks = 0; // Comparison count
  int n_samp = 0; // Sample strobes seen
  int i, p, n0; // Loop index, period, sample base
  logic g; // Display group snapshot
  logic [31:0] q, q2; // Read values
  int unsigned seed; // Seed result
  // Reset value table
  logic [7:0] ra [10] = '{A_RESET, A_CLKEN, A_MASK, A_FLAG, A_PRIO0,
    A_PRIO1, A_TPS, A_MODE, A_STOP, 8'h30};
  logic [31:0] rv [10] = '{32'h1, 32'h0, 32'hFF, 32'h0, 32'hFF, 32'hFF,
    32'h1, 32'h0, 32'h0, 32'h0};

  itc_top #(.DATA_RESET(DR), .SAMPLE_COUNT(SC)) DUT (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .count_event_in(ev),
    .switch_input_pin(pin), .channel3_irq(channel3_irq),
    .irq_level(irq_level), .interval_pulse(interval_pulse),
    .display_group(display_group), .switch_sample(switch_sample),
    .switch_state(switch_state));

  // Clock generator
  initial begin
    forever #20 clk = ~clk;
  end

  // Counts sample strobes
  always @(posedge clk) begin
    if (switch_sample === 1'b1) n_samp++;
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (k == 20) begin
      n_mismatch++;
      tally_and_finish();
    end
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  // Register read and compare
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  // Waits for an interval end, bounded
  task automatic wait_pulse(output int t);
    for (t = 1; t <= 40000; t++) begin
      @(posedge clk);
      if (interval_pulse === 1'b1) return;
    end
    n_mismatch++;
    tally_and_finish();
  endtask

  // No interval end during n cycles
  task automatic quiet(input int n);
    int k;
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if (interval_pulse !== 1'b0) k++;
    end
    chk(k, 0);
  endtask

  // Raises the event input n times, counts interval ends on the rises
  task automatic events(input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      ev <= 1'b1;
      @(posedge clk);
      if (interval_pulse === 1'b1) k++;
      ev <= 1'b0;
      @(posedge clk);
    end
  endtask

  // Tap exponent picked by a select code
  function automatic int texp(input logic [1:0] c, input logic [15:0] t);
    case (c)
      2'b00: return int'(t[3:0]);
      2'b01: return int'(t[9:8]);
      2'b10: return int'(t[7:4]);
      default: return int'(t[13:12]);
    endcase
  endfunction

  // Configures the channel, then times two ends
  task automatic measure(input int d, input logic [1:0] c,
                         input logic [15:0] t);
    int m;
    wr(A_STOP, 32'h0000_0008);
    wr(A_TPS, {16'h0000, t});
    wr(A_MODE, {16'h0000, c, 14'h0000});
    wr(A_DATA, 32'(d));
    wr(A_FLAG, 32'h0000_0000);
    wr(A_START, 32'h0000_0008);
    wait_pulse(m);
    wait_pulse(m);
    chk(m, 32'((d + 1) << texp(c, t)));
    rdchk(A_FLAG, 32'h0000_0020);
    chk(channel3_irq, 32'h0);
  endtask

  // Main sequence
  initial begin
    seed = $urandom(32'h842741c7);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 10; i++) rdchk(ra[i], rv[i]);
    chk(irq_level, 32'h3);
    wr(A_TPS, 32'h0000_0003);
    rdchk(A_TPS, 32'h0000_0001);
    wr(A_RESET, 32'h0000_0000);
    wr(A_TPS, 32'h0000_0003);
    rdchk(A_TPS, 32'h0000_0001);
    wr(A_CLKEN, 32'h0000_0001);
    wr(A_STOP, 32'h0000_0A0F);
    wr(A_MASK, 32'h0000_00FF);
    wr(A_TPS, 32'h0000_3210);
    rdchk(A_TPS, 32'h0000_3210);
    for (i = 0; i < 4; i++) measure(DR, i[1:0], 16'h3210);
    repeat (4) measure($urandom_range(20, 1), 2'b00,
                       16'($urandom_range(6, 0)));
    measure(0, 2'b00, 16'h000F);
    // Unmasking passes the pending request
    wr(A_MASK, 32'h0000_00DF);
    chk(channel3_irq, 32'h1);
    wr(A_MASK, 32'h0000_00FF);
    chk(channel3_irq, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(A_PRIO0, {26'h0, i[0], 5'h00});
      wr(A_PRIO1, {26'h0, i[1], 5'h00});
      chk(irq_level, 32'(i));
    end
    // Stop triggers, low and high byte
    measure(DR, 2'b00, 16'h0001);
    wr(A_STOP, 32'h0000_0000);
    wb(1'b0, A_STATUS, 32'h0, q);
    chk(q & 32'h8, 32'h8);
    wr(A_STOP, 32'h0000_0008);
    wb(1'b0, A_STATUS, 32'h0, q);
    chk(q & 32'h8, 32'h0);
    quiet(100);
    wr(A_START, 32'h0000_0008);
    wr(A_STOP, 32'h0000_0800);
    wb(1'b0, A_STATUS, 32'h0, q);
    chk(q & 32'h8, 32'h0);
    // Clock gate freezes the count
    wr(A_START, 32'h0000_0008);
    wr(A_CLKEN, 32'h0000_0000);
    wb(1'b0, A_STATUS, 32'h0, q);
    quiet(100);
    wb(1'b0, A_STATUS, 32'h0, q2);
    chk(q2 >> 16, q >> 16);
    wr(A_CLKEN, 32'h0000_0001);
    // Display group and switch sampling
    measure(DR, 2'b00, 16'h0000);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      pin <= 1'($urandom);
      wait_pulse(p);
      @(posedge clk);
      #1;
      g = display_group;
      n0 = n_samp;
      wait_pulse(p);
      #1;
      chk(display_group, {31'h0, ~g});
      repeat (2 * SC - 1) wait_pulse(p);
      @(posedge clk);
      #1;
      chk(n_samp - n0, 2);
      chk(switch_state, pin);
    end
    // External events as counting clock, two periods of three
    wr(A_STOP, 32'h0000_0008);
    wr(A_MODE, 32'h0000_1000);
    wr(A_DATA, 32'h0000_0002);
    wr(A_START, 32'h0000_0008);
    events(6, p);
    chk(p, 2);
    // Unit reset restores unit registers only
    wr(A_RESET, 32'h0000_0001);
    rdchk(A_MODE, 32'h0000_0000);
    rdchk(A_TPS, 32'h0000_0001);
    rdchk(A_MASK, 32'h0000_00FF);
    quiet(50);
    tally_and_finish();
  end

  // Watchdog against a hang
  initial begin
    #4000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
